/* File: src/err_led_pkg.sv */
// constants, encodings and texts for the error indicator
package err_led_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned QUARTER_MS = 250;
  localparam int unsigned QUARTER_CYCLES = CLK_HZ / 1000 * QUARTER_MS;
  localparam int unsigned TRACE_BAUD = 9600;
  localparam int unsigned BIT_CYCLES = CLK_HZ / TRACE_BAUD;
  localparam int unsigned WARN_SECONDS = 60;
  localparam logic [7:0] WARN_TICKS = 8'(WARN_SECONDS * 1000 / QUARTER_MS);
  localparam logic [2:0] EXT_PAUSE_TICKS = 3'h4;

  // error codes
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_HW_FAULT = 4'h1;
  localparam logic [3:0] CODE_SCRIPT = 4'h5;
  localparam logic [3:0] CODE_UNKNOWN_PROTO = 4'h6;
  localparam logic [3:0] CODE_TX_OVERFLOW = 4'h7;
  localparam logic [3:0] CODE_RESERVED_LAST = 4'hF;
  localparam logic [3:0] EXT_CODE_LAST = 4'hF;

  // trace message geometry
  localparam logic [4:0] LEN_START = 5'h08;
  localparam logic [4:0] LEN_ADDR = 5'h18;
  localparam logic [4:0] LEN_STATE = 5'h14;
  localparam logic [4:0] LEN_SCRIPT = 5'h14;
  localparam logic [7:0] TRACE_END = 8'h00;
  localparam logic [7:0] CH_CLOSE = 8'h29;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_HEX_OFS = 8'h37;

  // prefixes, left aligned in 80 bits
  localparam logic [79:0] START_TXT = 80'h2853_5441_5254_2900_0000;
  localparam logic [79:0] ADDR_PRE = 80'h2845_4C2D_4950_3A00_0000;
  localparam logic [79:0] STATE_PRE = 80'h2845_4C2D_5374_6174_653A;
  localparam logic [79:0] SCRIPT_PRE = 80'h2845_3A00_0000_0000_0000;
  localparam logic [79:0] LOC_PRE = 80'h2845_7874_4572_723A_0000;

  typedef enum logic [1:0] {
    MSG_START = 2'b00,
    MSG_ADDR = 2'b01,
    MSG_STATE = 2'b11,
    MSG_SCRIPT = 2'b10
  } msg_kind_t;

  typedef enum logic [1:0] {
    EXT_IDLE = 2'b00,
    EXT_DARK = 2'b01,
    EXT_LIT = 2'b11,
    EXT_PAUSE = 2'b10
  } ext_state_t;

  typedef enum logic {
    TR_IDLE = 1'b0,
    TR_SEND = 1'b1
  } trace_state_t;
endpackage

/* File: src/error_led_indicator.sv */
// error display on state and number leds, extension blink code, diagnostic trace
`timescale 1ns/1ps
// Operation
// - error: state led red, code on leds
// - codes 1-5 latched until power cycle
// - codes 6-15 cleared after one minute
// - user errors flash at half hertz
// - user error held for set time
// - config mode: leds show internal pattern
// - system flashes 1x/s, user once every 2 s
// - system codes 1-5 and reserved codes
// - system codes 7-14 mapping
// - user codes from delivered script
// - trace at 9600 baud, 8N1
// - parenthesised items ending in zero byte
// - port state message after a change; changes made before it is sent share one message
// - script error hex plus decimal locator
// - extension error flashes power led red
// - dark blinks count number, then pause
// - extension numbers span 1 to 15
module error_led_indicator
  import err_led_pkg::*;
#(
  parameter int unsigned QUARTER_CYCLES_P = err_led_pkg::QUARTER_CYCLES,
  parameter int unsigned BIT_CYCLES_P = err_led_pkg::BIT_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // error reports
  input wire logic sysErrValid,
  input wire logic [3:0] sysErrCode,
  input wire logic userErrValid,
  input wire logic [3:0] userErrCode,
  input wire logic [7:0] holdSeconds,
  // mode and extension board
  input wire logic configMode,
  input wire logic [3:0] cfgPattern,
  input wire logic [3:0] extErrCode,
  // trace sources
  input wire logic traceEnable,
  input wire logic [31:0] ipAddr,
  input wire logic [31:0] portState,
  input wire logic scriptErrValid,
  input wire logic [7:0] scriptErrNum,
  input wire logic [9:0] script_fault_locator,
  // leds and trace line
  output logic stateRed,
  output logic [3:0] errLed,
  output logic powerRed,
  output logic traceTxd
);
  import err_led_pkg::*;

  function automatic logic [7:0] hexChar(input logic [3:0] n);
    hexChar = (n < 4'hA) ? CH_ZERO + {4'h0, n} : CH_HEX_OFS + {4'h0, n};
  endfunction

  function automatic logic [7:0] decChar(input logic [9:0] v, input logic [1:0] pos);
    logic [9:0] q;
    q = (pos == 2'h2) ? v / 10'd100 : (pos == 2'h1) ? (v / 10'd10) % 10'd10 : v % 10'd10;
    decChar = CH_ZERO + q[7:0];
  endfunction

  function automatic logic [7:0] preByte(input logic [79:0] txt, input logic [4:0] idx);
    preByte = txt[79 - 8 * idx -: 8];
  endfunction

  // config mode arrives from switches: two flops first
  logic cfgMeta, cfgSync;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfgMeta <= 1'b0;
      cfgSync <= 1'b0;
    end else begin
      cfgMeta <= configMode;
      cfgSync <= cfgMeta;
    end
  end

  // quarter second tick and flash phases
  logic [23:0] quarterCnt;
  logic tick;
  logic [1:0] tickCnt;
  logic userPhase;
  wire logic sysPhase = tickCnt[1];
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      quarterCnt <= 24'h00_0000;
      tick <= 1'b0;
      tickCnt <= 2'h0;
      userPhase <= 1'b0;
    end else begin
      tick <= quarterCnt == 24'(QUARTER_CYCLES_P - 1);
      // wrap on the count itself so a quarter is exactly QUARTER_CYCLES_P clocks
      quarterCnt <= quarterCnt + 24'h00_0001;
      if (quarterCnt == 24'(QUARTER_CYCLES_P - 1)) begin
        quarterCnt <= 24'h00_0000;
      end
      if (tick) begin
        tickCnt <= tickCnt + 2'h1;
        if (tickCnt == 2'h3) begin
          userPhase <= ~userPhase;
        end
      end
    end
  end

  // error classes; code 0 is reserved and never shown
  wire logic sysNew = sysErrValid && sysErrCode != CODE_NONE;
  wire logic isSerious = sysErrCode <= CODE_SCRIPT;
  wire logic isWarn = sysErrCode >= CODE_UNKNOWN_PROTO;
  logic [3:0] seriousCode, warnCode, userCode;
  logic [7:0] warnTicks;
  logic [9:0] userTicks;

  // first serious error wins and stays until power is cycled
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      seriousCode <= CODE_NONE;
    end else if (sysNew && isSerious && seriousCode == CODE_NONE) begin
      seriousCode <= sysErrCode;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      warnCode <= CODE_NONE;
      warnTicks <= 8'h00;
    end else if (sysNew && isWarn) begin
      warnCode <= sysErrCode;
      warnTicks <= WARN_TICKS;
    end else if (tick && warnTicks != 8'h00) begin
      warnTicks <= warnTicks - 8'h01;
      if (warnTicks == 8'h01) begin
        warnCode <= CODE_NONE;
      end
    end
  end

  // hold of zero seconds clears at the next tick
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      userCode <= CODE_NONE;
      userTicks <= 10'h000;
    end else if (userErrValid && userErrCode != CODE_NONE) begin
      userCode <= userErrCode;
      userTicks <= {holdSeconds, 2'b00};
    end else if (tick && userCode != CODE_NONE) begin
      if (userTicks <= 10'h001) begin
        userCode <= CODE_NONE;
      end
      if (userTicks != 10'h000) begin
        userTicks <= userTicks - 10'h001;
      end
    end
  end

  // serious beats warning beats user
  wire logic dispActive = seriousCode != CODE_NONE || warnCode != CODE_NONE
                          || userCode != CODE_NONE;
  wire logic dispUser = seriousCode == CODE_NONE && warnCode == CODE_NONE;
  wire logic [3:0] dispCode = (seriousCode != CODE_NONE) ? seriousCode
                             : (warnCode != CODE_NONE) ? warnCode : userCode;
  wire logic flashOn = dispUser ? userPhase : sysPhase;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stateRed <= 1'b0;
      errLed <= 4'h0;
    end else if (cfgSync) begin
      stateRed <= sysPhase;
      errLed <= cfgPattern;
    end else begin
      stateRed <= dispActive;
      errLed <= (dispActive && flashOn) ? dispCode : 4'h0;
    end
  end

  // extension blink code on the power led
  ext_state_t extState;
  logic [3:0] blinkLeft;
  logic [2:0] extTicks;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      extState <= EXT_IDLE;
      blinkLeft <= 4'h0;
      extTicks <= 3'h0;
    end else if (tick) begin
      case (extState)
        EXT_IDLE: begin
          if (extErrCode != CODE_NONE) begin
            extState <= EXT_DARK;
            blinkLeft <= extErrCode;
          end
        end
        EXT_DARK: begin
          if (blinkLeft <= 4'h1) begin
            extState <= EXT_PAUSE;
            extTicks <= EXT_PAUSE_TICKS;
          end else begin
            extState <= EXT_LIT;
            blinkLeft <= blinkLeft - 4'h1;
          end
        end
        EXT_LIT: begin
          extState <= EXT_DARK;
        end
        EXT_PAUSE: begin
          if (extTicks > 3'h1) begin
            extTicks <= extTicks - 3'h1;
          end else if (extErrCode == CODE_NONE) begin
            extState <= EXT_IDLE;
          end else begin
            extState <= EXT_DARK;
            blinkLeft <= extErrCode;
          end
        end
        default: begin
          extState <= EXT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      powerRed <= 1'b0;
    end else begin
      powerRed <= extState != EXT_IDLE && extState != EXT_DARK;
    end
  end

  // trace pending flags; a new event beats the clear of a taken one
  trace_state_t trState;
  msg_kind_t msgKind;
  logic startPend, addrPend, statePend, scriptPend;
  logic [31:0] prevState, stateSnap, addrSnap;
  logic [7:0] errNumHold, errSnap;
  logic [9:0] locHold, locSnap;
  logic [4:0] traceIdx;
  logic [7:0] traceChar;
  logic [4:0] traceLen;
  logic txReady;
  wire logic stateChanged = traceEnable && portState != prevState;
  wire logic launch = trState == TR_IDLE && traceEnable
                      && (startPend || addrPend || statePend || scriptPend);
  wire msg_kind_t nextKind = startPend ? MSG_START : addrPend ? MSG_ADDR
                             : scriptPend ? MSG_SCRIPT : MSG_STATE;
  wire logic txValid = trState == TR_SEND;
  wire logic lastChar = traceIdx == traceLen - 5'h01;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      startPend <= 1'b1;
      addrPend <= 1'b1;
      statePend <= 1'b0;
      scriptPend <= 1'b0;
      prevState <= 32'h0000_0000;
      errNumHold <= 8'h00;
      locHold <= 10'h000;
    end else begin
      prevState <= portState;
      startPend <= startPend && !(launch && nextKind == MSG_START);
      addrPend <= addrPend && !(launch && nextKind == MSG_ADDR);
      statePend <= stateChanged || (statePend && !(launch && nextKind == MSG_STATE));
      scriptPend <= (scriptErrValid && traceEnable)
                    || (scriptPend && !(launch && nextKind == MSG_SCRIPT));
      if (scriptErrValid) begin
        errNumHold <= scriptErrNum;
        locHold <= script_fault_locator;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      trState <= TR_IDLE;
      msgKind <= MSG_START;
      traceIdx <= 5'h00;
      stateSnap <= 32'h0000_0000;
      addrSnap <= 32'h0000_0000;
      errSnap <= 8'h00;
      locSnap <= 10'h000;
    end else if (launch) begin
      trState <= TR_SEND;
      msgKind <= nextKind;
      traceIdx <= 5'h00;
      stateSnap <= portState;
      addrSnap <= ipAddr;
      errSnap <= errNumHold;
      locSnap <= locHold;
    end else if (txValid && txReady) begin
      traceIdx <= traceIdx + 5'h01;
      if (lastChar) begin
        trState <= TR_IDLE;
      end
    end
  end

  // character at the current index of the current message
  always_comb begin
    logic [4:0] j;
    j = traceIdx - 5'h07;
    traceChar = TRACE_END;
    traceLen = LEN_START;
    case (msgKind)
      MSG_START: begin
        if (traceIdx < 5'h07) traceChar = preByte(START_TXT, traceIdx);
      end
      MSG_ADDR: begin
        traceLen = LEN_ADDR;
        if (traceIdx < 5'h07) traceChar = preByte(ADDR_PRE, traceIdx);
        else if (traceIdx == 5'h16) traceChar = CH_CLOSE;
        else if (traceIdx == 5'h17) traceChar = TRACE_END;
        else if (j[1:0] == 2'h3) traceChar = CH_DOT;
        else traceChar = decChar({2'b00, addrSnap[8 * (3 - j[3:2]) +: 8]}, 2'h2 - j[1:0]);
      end
      MSG_STATE: begin
        traceLen = LEN_STATE;
        if (traceIdx < 5'h0A) traceChar = preByte(STATE_PRE, traceIdx);
        else if (traceIdx < 5'h12) traceChar = hexChar(stateSnap[4 * (17 - traceIdx) +: 4]);
        else if (traceIdx == 5'h12) traceChar = CH_CLOSE;
      end
      MSG_SCRIPT: begin
        traceLen = LEN_SCRIPT;
        if (traceIdx < 5'h03) traceChar = preByte(SCRIPT_PRE, traceIdx);
        else if (traceIdx == 5'h03) traceChar = hexChar(errSnap[7:4]);
        else if (traceIdx == 5'h04) traceChar = hexChar(errSnap[3:0]);
        else if (traceIdx == 5'h05) traceChar = CH_CLOSE;
        else if (traceIdx == 5'h06) traceChar = TRACE_END;
        else if (traceIdx < 5'h0F) traceChar = preByte(LOC_PRE, j);
        else if (traceIdx < 5'h12) traceChar = decChar(locSnap, 2'(5'h11 - traceIdx));
        else if (traceIdx == 5'h12) traceChar = CH_CLOSE;
      end
      default: traceChar = TRACE_END;
    endcase
  end

  trace_uart_tx #(.BIT_CYCLES_P(BIT_CYCLES_P)) u_tx (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .byteValid(txValid),
    .byteData(traceChar),
    .byteReady(txReady),
    .txd(traceTxd)
  );

  chk_serious_latched: assert property (@(posedge core_clk) disable iff (!arst_n)
    seriousCode != CODE_NONE |=> $stable(seriousCode)) else $error("serious code changed");
  chk_state_red: assert property (@(posedge core_clk) disable iff (!arst_n)
    (dispActive && !cfgSync) |=> stateRed) else $error("state led not red on error");
  chk_led_code: assert property (@(posedge core_clk) disable iff (!arst_n)
    (dispActive && !cfgSync && flashOn) |=> errLed == $past(dispCode))
    else $error("error leds do not show code");
  chk_warn_expiry: assert property (@(posedge core_clk) disable iff (!arst_n)
    (tick && warnTicks == 8'h01 && !sysNew) |=> warnCode == CODE_NONE)
    else $error("warning not cleared after timeout");
  chk_sys_rate: assert property (@(posedge core_clk) disable iff (!arst_n)
    (tick && tickCnt[0]) |=> sysPhase != $past(sysPhase)) else $error("system phase stuck");
  chk_user_rate: assert property (@(posedge core_clk) disable iff (!arst_n)
    (tick && tickCnt != 2'h3) |=> $stable(userPhase)) else $error("user phase too fast");
  chk_config_pattern: assert property (@(posedge core_clk) disable iff (!arst_n)
    cfgSync |=> errLed == $past(cfgPattern)) else $error("config pattern not shown");
  chk_ext_dark: assert property (@(posedge core_clk) disable iff (!arst_n)
    extState == EXT_DARK ##1 extState == EXT_DARK |-> !powerRed)
    else $error("power led lit in dark phase");
  chk_trace_term: assert property (@(posedge core_clk) disable iff (!arst_n)
    (txValid && txReady && lastChar) |-> traceChar == TRACE_END)
    else $error("message not zero terminated");
  chk_user_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    (userErrValid && userErrCode != CODE_NONE) |=> userCode == $past(userErrCode))
    else $error("user error not taken");
endmodule

/* File: src/trace_uart_tx.sv */
// serial transmitter for the diagnostic trace, 8 data bits, 1 stop, no parity
`timescale 1ns/1ps
module trace_uart_tx #(
  parameter int unsigned BIT_CYCLES_P = 4166
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // byte in
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  output logic byteReady,
  // line
  output logic txd
);
  logic [9:0] shiftReg;
  logic [3:0] bitsLeft;
  logic [12:0] baudCnt;
  wire logic accept = byteValid && byteReady;
  wire logic bitEnd = baudCnt == 13'(BIT_CYCLES_P - 1);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shiftReg <= 10'h3FF;
      bitsLeft <= 4'h0;
      baudCnt <= 13'h0000;
      byteReady <= 1'b1;
      txd <= 1'b1;
    end else if (accept) begin
      // stop, data lsb first, start
      shiftReg <= {1'b1, byteData, 1'b0};
      bitsLeft <= 4'hA;
      baudCnt <= 13'h0000;
      byteReady <= 1'b0;
      txd <= 1'b0;
    end else if (bitsLeft != 4'h0) begin
      if (bitEnd) begin
        baudCnt <= 13'h0000;
        bitsLeft <= bitsLeft - 4'h1;
        shiftReg <= {1'b1, shiftReg[9:1]};
        txd <= (bitsLeft == 4'h1) ? 1'b1 : shiftReg[1];
        byteReady <= bitsLeft == 4'h1;
      end else begin
        baudCnt <= baudCnt + 13'h0001;
      end
    end
  end
endmodule

/* File: test/test_error_led_indicator.sv */
// self-checking bench for the error indicator
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module test_error_led_indicator;
  import err_led_pkg::*;
  // short tick and bit so a warning minute fits the run
  localparam int QC = 20;
  localparam int BC = 8;
  logic core_clk, arst_n, sysErrValid, userErrValid, configMode, traceEnable;
  logic scriptErrValid, stateRed, powerRed, traceTxd, rxStrobe, frameErr;
  logic [3:0] sysErrCode, userErrCode, cfgPattern, extErrCode, errLed, orLed;
  logic [7:0] holdSeconds, scriptErrNum, rxByte;
  logic [31:0] ipAddr, portState;
  logic [9:0] script_fault_locator;
  logic [7:0] rxQ[$];
  logic [7:0] expQ[$];
  // bit4 set = user report, low nibble = code
  logic [4:0] rows [21] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
    5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h13, 5'h15, 5'h16, 5'h19, 5'h1B};
  int n_mismatch = 0;
  int total_checks = 0;
  int litCnt, riseCnt, redCnt, lowTx, pwrCnt, fallCnt;
  int extCodes [3] = '{1, 3, 15};

  error_led_indicator #(.QUARTER_CYCLES_P(QC), .BIT_CYCLES_P(BC)) uut (
    .core_clk(core_clk), .arst_n(arst_n), .sysErrValid(sysErrValid),
    .sysErrCode(sysErrCode), .userErrValid(userErrValid), .userErrCode(userErrCode),
    .holdSeconds(holdSeconds), .configMode(configMode), .cfgPattern(cfgPattern),
    .extErrCode(extErrCode), .traceEnable(traceEnable), .ipAddr(ipAddr),
    .portState(portState), .scriptErrValid(scriptErrValid), .scriptErrNum(scriptErrNum),
    .script_fault_locator(script_fault_locator), .stateRed(stateRed), .errLed(errLed),
    .powerRed(powerRed), .traceTxd(traceTxd));

  trace_monitor #(.BIT_CYCLES_P(BC)) mon (
    .core_clk(core_clk), .arst_n(arst_n), .traceTxd(traceTxd),
    .rxStrobe(rxStrobe), .rxByte(rxByte), .frameErr(frameErr));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) if (rxStrobe === 1'b1) rxQ.push_back(rxByte);

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge core_clk);
    arst_n = 1'b0;
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
  endtask

  task automatic report(input logic isUser, input logic [3:0] code);
    @(negedge core_clk);
    userErrValid = isUser;
    sysErrValid = ~isUser;
    userErrCode = code;
    sysErrCode = code;
    @(negedge core_clk);
    userErrValid = 1'b0;
    sysErrValid = 1'b0;
  endtask

  // gather lit time, flash starts, red time and power led dark starts
  task automatic measure(input int cycles);
    logic prevLit, prevPwr;
    litCnt = 0;
    riseCnt = 0;
    redCnt = 0;
    lowTx = 0;
    pwrCnt = 0;
    fallCnt = 0;
    orLed = 4'h0;
    prevLit = |errLed;
    prevPwr = powerRed;
    repeat (cycles) begin
      @(negedge core_clk);
      if (|errLed) litCnt++;
      if (|errLed && !prevLit) riseCnt++;
      if (prevPwr && !powerRed) fallCnt++;
      if (powerRed) pwrCnt++;
      if (stateRed) redCnt++;
      if (!traceTxd) lowTx++;
      prevLit = |errLed;
      prevPwr = powerRed;
      orLed = orLed | errLed;
    end
  endtask

  task automatic push_str(input string s);
    foreach (s[i]) expQ.push_back(s[i]);
  endtask

  // bounded wait for the expected byte count, then compare byte by byte
  task automatic check_trace();
    int k;
    k = 0;
    while (rxQ.size() < expQ.size() && k < 20000) begin
      @(negedge core_clk);
      k++;
    end
    `CHK(rxQ.size(), expQ.size());
    foreach (expQ[i]) if (i < rxQ.size()) `CHK(rxQ[i], expQ[i]);
    expQ.delete();
    rxQ.delete();
  endtask

  initial begin
    arst_n = 1'b0;
    sysErrValid = 1'b0;
    sysErrCode = 4'h0;
    userErrValid = 1'b0;
    userErrCode = 4'h0;
    holdSeconds = 8'h10;
    configMode = 1'b0;
    cfgPattern = 4'h0;
    extErrCode = 4'h0;
    traceEnable = 1'b0;
    ipAddr = 32'hAC10_30CB;
    portState = 32'h2020_20E2;
    scriptErrValid = 1'b0;
    scriptErrNum = 8'h00;
    script_fault_locator = 10'h000;
    repeat (5) @(negedge core_clk);
    `CHK({stateRed, errLed, powerRed, traceTxd}, 7'h01);
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
    $display("reset test done");
    // ordinary reports, one per fresh reset
    for (int i = 0; i < 21; i++) begin
      do_reset();
      report(rows[i][4], rows[i][3:0]);
      repeat (2) @(negedge core_clk);
      measure(16 * QC);
      `CHK(orLed, rows[i][3:0]);
      `CHK(litCnt, (rows[i][3:0] == 4'h0) ? 0 : 8 * QC);
      `CHK(riseCnt, (rows[i][3:0] == 4'h0) ? 0 : (rows[i][4] ? 2 : 4));
      `CHK(redCnt != 0, rows[i][3:0] != 4'h0);
      `CHK(lowTx, 0);
      $display("row %0d done", i);
    end
    // first serious code kept past the warning time, later serious code refused
    do_reset();
    report(1'b0, 4'h2);
    report(1'b0, 4'h3);
    report(1'b0, 4'h9);
    repeat (250 * QC) @(negedge core_clk);
    measure(8 * QC);
    `CHK(orLed, 4'h2);
    do_reset();
    measure(8 * QC);
    `CHK(orLed, 4'h0);
    $display("serious test done");
    // warning stays for 240 ticks, then clears itself
    report(1'b0, 4'hE);
    repeat (228 * QC) @(negedge core_clk);
    measure(8 * QC);
    `CHK(orLed, 4'hE);
    repeat (8 * QC) @(negedge core_clk);
    measure(8 * QC);
    `CHK(orLed, 4'h0);
    `CHK(redCnt, 0);
    $display("warning test done");
    // user hold of 2 s is 8 ticks
    do_reset();
    holdSeconds = 8'h02;
    report(1'b1, 4'h6);
    measure(8 * QC);
    `CHK(orLed, 4'h6);
    repeat (4 * QC) @(negedge core_clk);
    measure(16 * QC);
    `CHK(orLed, 4'h0);
    holdSeconds = 8'h10;
    $display("user hold test done");
    // config mode shows the internal pattern steadily
    configMode = 1'b1;
    cfgPattern = 4'h9;
    repeat (4) @(negedge core_clk);
    measure(8 * QC);
    `CHK(orLed, 4'h9);
    `CHK(litCnt, 8 * QC);
    configMode = 1'b0;
    $display("config test done");
    // extension blink code over exactly one sequence period
    foreach (extCodes[j]) begin
      do_reset();
      extErrCode = 4'(extCodes[j]);
      repeat ((2 * extCodes[j] + 5) * QC) @(negedge core_clk);
      measure((2 * extCodes[j] + 3) * QC);
      `CHK(fallCnt, extCodes[j]);
      `CHK(pwrCnt, (extCodes[j] + 3) * QC);
      `CHK(orLed, 4'h0);
      extErrCode = 4'h0;
      $display("extension %0d test done", extCodes[j]);
    end
    // power-on trace, then script error beating a port change
    traceEnable = 1'b1;
    rxQ.delete();
    do_reset();
    push_str("(START)");
    expQ.push_back(8'h00);
    push_str("(EL-IP:172.016.048.203)");
    expQ.push_back(8'h00);
    // the first port state after reset counts as a change and is reported
    push_str("(EL-State:202020E2)");
    expQ.push_back(8'h00);
    check_trace();
    @(negedge core_clk);
    portState = 32'h2020_10E2;
    scriptErrNum = 8'h21;
    script_fault_locator = 10'h01E;
    scriptErrValid = 1'b1;
    @(negedge core_clk);
    scriptErrValid = 1'b0;
    push_str("(E:21)");
    expQ = {expQ, 8'h00, 8'h28, 8'h45, 8'h78, 8'h74, 8'h45, 8'h72, 8'h72};
    push_str(":030)");
    expQ.push_back(8'h00);
    push_str("(EL-State:202010E2)");
    expQ.push_back(8'h00);
    check_trace();
    `CHK(frameErr, 1'b0);
    $display("trace test done");
    stop_test();
  end

  initial begin
    repeat (80000) @(posedge core_clk);
    n_mismatch++;
    $display("watchdog expired");
    stop_test();
  end
endmodule

/* File: test/trace_monitor.sv */
// serial monitor model that decodes the diagnostic trace line into bytes
`timescale 1ns/1ps
module trace_monitor #(
  parameter int unsigned BIT_CYCLES_P = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // trace line in
  input wire logic traceTxd,
  // decoded bytes
  output logic rxStrobe,
  output logic [7:0] rxByte,
  output logic frameErr
);
  logic [7:0] shiftIn;

  initial begin
    rxStrobe = 1'b0;
    rxByte = 8'h00;
    frameErr = 1'b0;
    shiftIn = 8'h00;
    forever begin
      @(posedge core_clk);
      rxStrobe <= 1'b0;
      if (arst_n === 1'b1 && traceTxd === 1'b0) begin
        // sample mid-bit, lsb first, 8 data bits
        repeat (BIT_CYCLES_P / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES_P) @(posedge core_clk);
          shiftIn[i] = traceTxd;
        end
        repeat (BIT_CYCLES_P) @(posedge core_clk);
        // no parity, so the next sample must be the stop bit
        if (traceTxd !== 1'b1) frameErr <= 1'b1;
        rxByte <= shiftIn;
        rxStrobe <= 1'b1;
      end
    end
  end
endmodule
